// [hw/asf_pkg.sv]
package asf_pkg;

  // ****************************************************************
  // flag byte layout
  // ****************************************************************
  localparam int FLG_C  = 0;  // carry
  localparam int FLG_N  = 1;  // subtract
  localparam int FLG_PV = 2;  // parity / overflow
  localparam int FLG_U3 = 3;  // no defined status
  localparam int FLG_H  = 4;  // half carry
  localparam int FLG_U5 = 5;  // no defined status
  localparam int FLG_Z  = 6;  // zero
  localparam int FLG_S  = 7;  // sign

  // reset value of both flag bytes
  localparam logic [7:0] FLAG_RST = 8'h00;
  // defined status bits; positions 3 and 5 always read zero
  localparam logic [7:0] FLAG_MASK = 8'hd7;

  // ****************************************************************
  // register map (apb byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADR_MAIN   = 12'h000;  // main_flag_byte
  localparam logic [11:0] ADR_SHADOW = 12'h004;  // shadow_flag_byte
  localparam logic [11:0] ADR_RESULT = 12'h008;  // last result byte, read only
  localparam logic [11:0] ADR_COND   = 12'h00c;  // branch condition test, rw

  // condition register field positions
  localparam int CND_SEL_LO = 0;  // 3-bit condition select
  localparam int CND_SEL_HI = 2;
  localparam int CND_HIT    = 8;  // read only: condition holds

  // ****************************************************************
  // operation codes issued by the sequencer
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NONE   = 5'h00,
    OP_ADD    = 5'h01,  // add, carry_in used for add-with-carry
    OP_SUB    = 5'h02,  // subtract, also compare
    OP_AND    = 5'h03,
    OP_OR     = 5'h04,
    OP_XOR    = 5'h05,
    OP_RLC    = 5'h06,  // rotate left circular
    OP_RRC    = 5'h07,  // rotate right circular
    OP_RL     = 5'h08,  // rotate left through carry
    OP_RR     = 5'h09,  // rotate right through carry
    OP_SLA    = 5'h0a,  // arith_shift_left
    OP_SRA    = 5'h0b,  // arith_shift_right
    OP_SRL    = 5'h0c,  // logic_shift_right
    OP_DAA    = 5'h0d,  // decimal_adjust_op
    OP_SCF    = 5'h0e,  // force_carry_op
    OP_CCF    = 5'h0f,  // invert_carry_op
    OP_BLKCP  = 5'h10,  // copy_step_up / search_step_up
    OP_BLKIO  = 5'h11,  // block_input_up / block_output_up/down
    OP_IEC    = 5'h12,  // accumulator from vector base / refresh
    OP_PORTIN = 5'h13,  // register input via count register
    OP_BIT    = 5'h14,  // single-bit test
    OP_SWAP   = 5'h15   // exchange main and shadow byte
  } asf_op_t;

  // conditions that branches may test (sign, zero, carry, p/v only)
  typedef enum logic [2:0] {
    CND_NZ = 3'h0,
    CND_Z  = 3'h1,
    CND_NC = 3'h2,
    CND_C  = 3'h3,
    CND_PO = 3'h4,
    CND_PE = 3'h5,
    CND_P  = 3'h6,
    CND_M  = 3'h7
  } asf_cond_t;

  // request from the sequencer
  typedef struct packed {
    logic        valid;        // one-cycle strobe
    asf_op_t     op;
    logic [7:0]  opa;          // accumulator / operand register
    logic [7:0]  opb;          // second operand or bit index
    logic        carry_in;     // use current carry as add/sub input
    logic        cnt_zero;     // decremented count reached zero
    logic        ie_copy;      // interrupt_enable_copy
  } asf_req_t;

  // register state
  typedef struct packed {
    logic [7:0]  main_r;
    logic [7:0]  shadow_r;
    logic [7:0]  result_r;
    logic [2:0]  cond_r;
    logic        hit_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
  } asf_state_t;

endpackage

// [hw/asf_flags.sv]
// How it works
// - sign 7, zero 6, p/v 2, carry 0
// - main and shadow byte; bits 3,5 undefined
// - branches test only c, p/v, z, s
// - carry is carry-out on add, borrow on sub
// - decimal adjust sets carry when correcting the upper digit
// - through-carry rotates use carry as ninth bit
// - left shifts take bit 7, right bit 0
// - and, or, xor clear carry
// - force carry sets, invert carry complements
// - add clears subtract, sub sets it
// - signed overflow from operand and result signs
// - overflow equals carry-in xor carry-out of sign
// - logic and rotate p/v is even parity
// - block copy/search p/v clear at count zero
// - vector/refresh load copies interrupt enable
// - port input sets parity, zero and sign
// - half carry from bit 3 or borrow bit 4
// - zero flag when result byte is zero
// - compare sets zero on equality
// - bit test zero is inverted tested bit
// - block i/o zero when count reaches zero
// - sign is result bit 7
module asf_flags
  import asf_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // sequencer request
  input  wire asf_req_t    req,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flag outputs
  output logic      [7:0]  flags,
  output logic      [7:0]  result,
  output logic             cond_hit
);

  // ****************************************************************
  // state
  // ****************************************************************
  asf_state_t st_r;    // all registers
  asf_state_t st_nxt;  // next value

  // ****************************************************************
  // helpers
  // ****************************************************************
  // even parity of a byte: one when count of set bits is even
  function automatic logic par_even(input logic [7:0] v);
    par_even = ~(^v);
  endfunction

  // condition evaluation over the four testable flags
  function automatic logic cond_eval(input logic [2:0] sel, input logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (asf_cond_t'(sel))
      CND_NZ: r = ~f[FLG_Z];
      CND_Z:  r = f[FLG_Z];
      CND_NC: r = ~f[FLG_C];
      CND_C:  r = f[FLG_C];
      CND_PO: r = ~f[FLG_PV];
      CND_PE: r = f[FLG_PV];
      CND_P:  r = ~f[FLG_S];
      CND_M:  r = f[FLG_S];
    endcase
    cond_eval = r;
  endfunction

  // ****************************************************************
  // flag computation
  // ****************************************************************
  logic [7:0] fl;      // current main flags
  logic [7:0] fn;      // next flags from the operation
  logic [7:0] res;     // result byte
  logic [4:0] lo_sum;  // low nibble sum with carry out
  logic [7:0] lo7;     // low seven bits sum with carry into sign
  logic [8:0] full;    // full nine-bit sum
  logic       cin;     // carry into bit 0
  logic       c7in;    // carry into the sign bit
  logic [7:0] corr;    // decimal correction
  logic       dcy;     // decimal carry

  always_comb
  begin
    fl     = st_r.main_r;
    fn     = fl;
    res    = st_r.result_r;
    cin    = req.carry_in & fl[FLG_C];
    lo_sum = 5'h00;
    lo7    = 8'h00;
    full   = 9'h000;
    c7in   = 1'b0;
    corr   = 8'h00;
    dcy    = 1'b0;
    unique case (req.op)
      // addition
      OP_ADD:
      begin
        full   = {1'b0, req.opa} + {1'b0, req.opb} + {8'h00, cin};
        lo_sum = {1'b0, req.opa[3:0]} + {1'b0, req.opb[3:0]} + {4'h0, cin};
        lo7    = {1'b0, req.opa[6:0]} + {1'b0, req.opb[6:0]} + {7'h00, cin};
        c7in   = lo7[7];
        res    = full[7:0];
        fn[FLG_C]  = full[8];
        fn[FLG_H]  = lo_sum[4];
        fn[FLG_PV] = c7in ^ full[8];
        fn[FLG_N]  = 1'b0;
      end
      // subtraction, compare shares it
      OP_SUB:
      begin
        full   = {1'b0, req.opa} - {1'b0, req.opb} - {8'h00, cin};
        lo_sum = {1'b0, req.opa[3:0]} - {1'b0, req.opb[3:0]} - {4'h0, cin};
        res    = full[7:0];
        fn[FLG_C]  = full[8];
        fn[FLG_H]  = lo_sum[4];
        fn[FLG_PV] = (req.opa[7] ^ req.opb[7]) & (req.opa[7] ^ full[7]);
        fn[FLG_N]  = 1'b1;
        fn[FLG_Z]  = (full[7:0] == 8'h00);
      end
      // logical group
      OP_AND, OP_OR, OP_XOR:
      begin
        if (req.op == OP_AND)
        begin
          res = req.opa & req.opb;
        end
        else if (req.op == OP_OR)
        begin
          res = req.opa | req.opb;
        end
        else
        begin
          res = req.opa ^ req.opb;
        end
        fn[FLG_C]  = 1'b0;
        fn[FLG_N]  = 1'b0;
        fn[FLG_H]  = (req.op == OP_AND);
        fn[FLG_PV] = par_even(res);
      end
      // rotates and shifts
      OP_RLC, OP_RRC, OP_RL, OP_RR, OP_SLA, OP_SRA, OP_SRL:
      begin
        unique case (req.op)
          OP_RL:   res = {req.opa[6:0], fl[FLG_C]};
          OP_RR:   res = {fl[FLG_C], req.opa[7:1]};
          OP_RLC:  res = {req.opa[6:0], req.opa[7]};
          OP_RRC:  res = {req.opa[0], req.opa[7:1]};
          OP_SLA:  res = {req.opa[6:0], 1'b0};
          OP_SRA:  res = {req.opa[7], req.opa[7:1]};
          default: res = {1'b0, req.opa[7:1]};
        endcase
        if (req.op == OP_RLC || req.op == OP_RL || req.op == OP_SLA)
        begin
          fn[FLG_C] = req.opa[7];
        end
        else
        begin
          fn[FLG_C] = req.opa[0];
        end
        fn[FLG_N]  = 1'b0;
        fn[FLG_H]  = 1'b0;
        fn[FLG_PV] = par_even(res);
      end
      // decimal adjust of accumulator
      OP_DAA:
      begin
        dcy = fl[FLG_C] | (req.opa > 8'h99);
        if (fl[FLG_H] | (req.opa[3:0] > 4'h9))
        begin
          corr[3:0] = 4'h6;
        end
        if (dcy)
        begin
          corr[7:4] = 4'h6;
        end
        res = fl[FLG_N] ? (req.opa - corr) : (req.opa + corr);
        fn[FLG_C] = dcy;
        fn[FLG_H] = fl[FLG_N] ? (fl[FLG_H] & (req.opa[3:0] < 4'h6))
                              : (req.opa[3:0] > 4'h9);
        fn[FLG_PV] = par_even(res);
      end
      // carry control
      OP_SCF:
      begin
        fn[FLG_C] = 1'b1;
        fn[FLG_N] = 1'b0;
        fn[FLG_H] = 1'b0;
      end
      OP_CCF:
      begin
        fn[FLG_C] = ~fl[FLG_C];
        fn[FLG_N] = 1'b0;
        fn[FLG_H] = fl[FLG_C];
      end
      // block copy and search step
      OP_BLKCP:
      begin
        fn[FLG_PV] = ~req.cnt_zero;
        fn[FLG_Z]  = (req.opa == req.opb);
        fn[FLG_N]  = 1'b0;
        fn[FLG_H]  = 1'b0;
      end
      // non-repeating block i/o step
      OP_BLKIO:
      begin
        fn[FLG_Z] = req.cnt_zero;
        fn[FLG_N] = 1'b1;
      end
      // accumulator from vector base or refresh counter
      OP_IEC:
      begin
        res = req.opa;
        fn[FLG_PV] = req.ie_copy;
        fn[FLG_N]  = 1'b0;
        fn[FLG_H]  = 1'b0;
      end
      // input through count register
      OP_PORTIN:
      begin
        res = req.opa;
        fn[FLG_PV] = par_even(res);
        fn[FLG_N]  = 1'b0;
        fn[FLG_H]  = 1'b0;
      end
      // single-bit test
      OP_BIT:
      begin
        fn[FLG_Z] = ~req.opa[req.opb[2:0]];
        fn[FLG_H] = 1'b1;
        fn[FLG_N] = 1'b0;
      end
      default:
      begin
        fn = fl;
      end
    endcase
    // result-based zero and sign for operations that yield a byte
    if (req.op inside {OP_ADD, OP_AND, OP_OR, OP_XOR, OP_RLC, OP_RRC, OP_RL,
                       OP_RR, OP_SLA, OP_SRA, OP_SRL, OP_DAA, OP_IEC, OP_PORTIN})
    begin
      fn[FLG_Z] = (res == 8'h00);
      fn[FLG_S] = res[7];
    end
    if (req.op == OP_SUB)
    begin
      fn[FLG_S] = res[7];
    end
  end

  // ****************************************************************
  // next state: sequencer and apb
  // ****************************************************************
  logic       acc;   // apb access phase
  logic [7:0] wb;    // write byte, undefined positions masked

  always_comb
  begin
    st_nxt = st_r;
    acc    = psel & penable;
    wb     = pwdata[7:0] & FLAG_MASK;
    st_nxt.pready_r  = 1'b0;
    st_nxt.pslverr_r = 1'b0;
    // sequencer update has priority over a software write of either flag byte
    if (req.valid && req.op == OP_SWAP)
    begin
      st_nxt.main_r   = st_r.shadow_r;
      st_nxt.shadow_r = st_r.main_r;
    end
    else if (req.valid)
    begin
      // fixed layout, 3 and 5 zero
      st_nxt.main_r   = fn & FLAG_MASK;
      st_nxt.result_r = res;
    end
    else if (acc && pwrite && !st_r.pready_r)
    begin
      if (paddr == ADR_MAIN)
      begin
        st_nxt.main_r = wb;
      end
      else if (paddr == ADR_SHADOW)
      begin
        st_nxt.shadow_r = wb;
      end
    end
    // condition select is software owned
    if (acc && pwrite && !st_r.pready_r && paddr == ADR_COND)
    begin
      st_nxt.cond_r = pwdata[CND_SEL_HI:CND_SEL_LO];
    end
    st_nxt.hit_r = cond_eval(st_nxt.cond_r, st_nxt.main_r);
    // one wait state: answer in the cycle after the access phase starts
    // ready gates the decode only for one cycle, so a held access phase is answered again every second cycle
    if (acc && !st_r.pready_r)
    begin
      st_nxt.pready_r = 1'b1;
      st_nxt.prdata_r = 32'h0000_0000;
      unique case (paddr)
        ADR_MAIN:   st_nxt.prdata_r = {24'h00_0000, st_r.main_r};
        ADR_SHADOW: st_nxt.prdata_r = {24'h00_0000, st_r.shadow_r};
        ADR_RESULT: st_nxt.prdata_r = {24'h00_0000, st_r.result_r};
        ADR_COND:
        begin
          st_nxt.prdata_r[CND_SEL_HI:CND_SEL_LO] = st_r.cond_r;
          st_nxt.prdata_r[CND_HIT]               = st_r.hit_r;
        end
        default:    st_nxt.pslverr_r = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '{main_r: FLAG_RST, shadow_r: FLAG_RST, result_r: 8'h00,
                cond_r: 3'h0, hit_r: 1'b0, prdata_r: 32'h0000_0000,
                pready_r: 1'b0, pslverr_r: 1'b0};
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign prdata   = st_r.prdata_r;
  assign pready   = st_r.pready_r;
  assign pslverr  = st_r.pslverr_r;
  assign flags    = st_r.main_r;
  assign result   = st_r.result_r;
  assign cond_hit = st_r.hit_r;

endmodule

// [test/asf_checker.sv]
module asf_checker
  import asf_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  // sequencer and bus
  input wire asf_req_t   req,
  input wire logic       pready,
  input wire logic       pslverr,
  // watched outputs
  input wire logic [7:0] flags,
  input wire logic [7:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helper terms, sampled with the request
  // ****************************************
  logic       go;    // request taken this edge
  logic [8:0] sum9;  // plain add with carry out
  logic       ovf;   // like signs in, other sign out
  logic       tst;   // bit picked by a bit test
  assign go   = clk_en && req.valid;
  assign sum9 = {1'b0, req.opa} + {1'b0, req.opb};
  assign ovf  = (req.opa[7] == req.opb[7]) && (sum9[7] != req.opa[7]);
  assign tst  = req.opa[req.opb[2:0]];

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  spare_bits_a: assert property (!flags[FLG_U3] && !flags[FLG_U5])
    else $error("spare flag bit set");
  add_carry_a: assert property (go && req.op == OP_ADD && !req.carry_in |=>
    flags[FLG_C] == $past(sum9[8]) && flags[FLG_PV] == $past(ovf) && !flags[FLG_N])
    else $error("add flags wrong");
  sub_mark_a: assert property (go && req.op == OP_SUB |=>
    flags[FLG_N] && flags[FLG_Z] == (result == 8'h00))
    else $error("subtract flags wrong");
  logic_ops_a: assert property (go && req.op inside {OP_AND, OP_OR, OP_XOR} |=>
    !flags[FLG_C] && flags[FLG_PV] == ~^result && flags[FLG_S] == result[7])
    else $error("logic op flags wrong");
  carry_flip_a: assert property (go && req.op == OP_CCF |=>
    flags[FLG_C] != $past(flags[FLG_C]))
    else $error("carry not inverted");
  bit_test_a: assert property (go && req.op == OP_BIT |=> flags[FLG_Z] == !$past(tst))
    else $error("bit test zero wrong");
  blk_count_a: assert property (go && req.op == OP_BLKCP |=>
    flags[FLG_PV] == !$past(req.cnt_zero))
    else $error("block p/v wrong");
  blk_io_a: assert property (go && req.op == OP_BLKIO |=>
    flags[FLG_Z] == $past(req.cnt_zero))
    else $error("block i/o zero wrong");
  ie_copy_a: assert property (go && req.op == OP_IEC |=>
    flags[FLG_PV] == $past(req.ie_copy))
    else $error("enable copy wrong");
  port_in_a: assert property (go && req.op == OP_PORTIN |=>
    flags[FLG_S] == $past(req.opa[7]) && flags[FLG_PV] == ~^$past(req.opa))
    else $error("port input flags wrong");
  // bus error only with ready
  bus_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule

bind asf_flags asf_checker i_asf_checker (.clk(clk), .rstn(rstn), .clk_en(clk_en),
  .req(req), .pready(pready), .pslverr(pslverr), .flags(flags), .result(result));

// [test/asf_seq_model.sv]
module asf_seq_model
  import asf_pkg::*;
(
  // clock
  input wire logic clk,
  // request to the flag logic
  output asf_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // one strobed request; side is carry_in, cnt_zero, ie_copy
  task automatic issue(input asf_op_t o, input logic [7:0] a, input logic [7:0] b,
                       input logic [2:0] s);
    @(posedge clk);
    req <= {1'b1, o, a, b, s};
    @(posedge clk);
    // operands scrambled so stale values never look valid
    req <= {1'b0, OP_NONE, ~a, ~b, ~s};
  endtask
endmodule

// [test/test_alu_status_flags.sv]
module test_alu_status_flags
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, clk_en, psel, penable, pwrite, pready, pslverr, cond_hit, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  flags, result;
  asf_req_t    req;
  int          error_cnt, checks_done, cyc;

  asf_flags i_asf_flags (.clk(clk), .rstn(rstn), .clk_en(clk_en), .req(req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags(flags), .result(result), .cond_hit(cond_hit));
  asf_seq_model i_asf_seq_model (.clk(clk), .req(req));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic fb(input string nm, input int pos, input logic v);
    chk(nm, {31'h0, flags[pos]}, {31'h0, v});
  endtask

  // apb transfer: held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input asf_op_t o, input logic [7:0] a, input logic [7:0] b,
                    input logic [2:0] s = 3'h0);
    i_asf_seq_model.issue(o, a, b, s);
    #1;
  endtask

  task automatic lg(input asf_op_t o, input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] f);
    op(OP_SCF, 8'h00, 8'h00);
    op(o, a, b);
    chk("logic flags", {24'h0, flags}, {24'h0, f});
  endtask

  // carry is set first, so through-carry rotates pull in a one
  task automatic rt(input asf_op_t o, input logic [7:0] a, input logic [7:0] r,
                    input logic c);
    op(OP_SCF, 8'h00, 8'h00);
    op(o, a, 8'h00);
    chk("rot result", {24'h0, result}, {24'h0, r});
    fb("rot carry", FLG_C, c);
    fb("rot parity", FLG_PV, ~^r);
  endtask

  task automatic t_arith();
    op(OP_ADD, 8'h78, 8'h69);
    chk("add flags", {24'h0, flags}, 32'h94);
    chk("add result", {24'h0, result}, 32'he1);
    op(OP_ADD, 8'hff, 8'h01);
    chk("wrap flags", {24'h0, flags}, 32'h51);
    op(OP_SUB, 8'h7f, 8'hc0);
    chk("sub flags", {24'h0, flags}, 32'h87);
    op(OP_SUB, 8'h42, 8'h42);
    chk("cmp flags", {24'h0, flags}, 32'h42);
    op(OP_SUB, 8'h10, 8'h01);
    chk("borrow flags", {24'h0, flags}, 32'h12);
    // add with carry: the stored carry ripples into the upper nibble
    op(OP_SCF, 8'h00, 8'h00);
    op(OP_ADD, 8'h0f, 8'h00, 3'h4);
    chk("adc flags", {24'h0, flags}, 32'h10);
    chk("adc result", {24'h0, result}, 32'h10);
  endtask

  task automatic t_shift();
    lg(OP_AND, 8'hf0, 8'h3c, 8'h14);
    lg(OP_OR, 8'hf0, 8'h0f, 8'h84);
    lg(OP_XOR, 8'h55, 8'h55, 8'h44);
    rt(OP_RLC, 8'h81, 8'h03, 1'b1);
    rt(OP_RRC, 8'h01, 8'h80, 1'b1);
    rt(OP_RL, 8'h80, 8'h01, 1'b1);
    rt(OP_RR, 8'h02, 8'h81, 1'b0);
    rt(OP_SLA, 8'h80, 8'h00, 1'b1);
    rt(OP_SRA, 8'h81, 8'hc0, 1'b1);
    rt(OP_SRL, 8'h81, 8'h40, 1'b1);
  endtask

  task automatic t_misc();
    op(OP_CCF, 8'h00, 8'h00);
    fb("ccf", FLG_C, 1'b0);
    op(OP_ADD, 8'h99, 8'h01);
    op(OP_DAA, 8'h9a, 8'h00);
    chk("daa result", {24'h0, result}, 32'h0);
    fb("daa carry", FLG_C, 1'b1);
    op(OP_BIT, 8'h20, 8'h05);
    fb("bit set", FLG_Z, 1'b0);
    op(OP_BIT, 8'h20, 8'h04);
    fb("bit clear", FLG_Z, 1'b1);
    op(OP_BLKCP, 8'h33, 8'h33, 3'h2);
    fb("blk end", FLG_PV, 1'b0);
    fb("blk match", FLG_Z, 1'b1);
    op(OP_BLKCP, 8'h33, 8'h34);
    fb("blk more", FLG_PV, 1'b1);
    op(OP_BLKIO, 8'h00, 8'h00, 3'h2);
    fb("io end", FLG_Z, 1'b1);
    op(OP_BLKIO, 8'h00, 8'h00);
    fb("io more", FLG_Z, 1'b0);
    op(OP_IEC, 8'h00, 8'h00, 3'h1);
    fb("ie copy", FLG_PV, 1'b1);
    op(OP_PORTIN, 8'h80, 8'h00);
    chk("port neg", {24'h0, flags & 8'hc4}, 32'h80);
    op(OP_PORTIN, 8'h00, 8'h00);
    chk("port zero", {24'h0, flags & 8'hc4}, 32'h44);
  endtask

  task automatic t_regs();
    logic [7:0] hit;
    hit = 8'h5a;
    apb(1'b1, ADR_MAIN, 32'hff);
    apb(1'b0, ADR_MAIN, 32'h0);
    chk("main rd", rd, 32'hd7);
    apb(1'b1, ADR_MAIN, 32'h41);
    fb("zero pos", FLG_Z, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, ADR_COND, i);
      apb(1'b0, ADR_COND, 32'h0);
      chk("cond rd", rd, {23'h0, hit[i], 5'h0, 3'(i)});
      chk("cond pin", {31'h0, cond_hit}, {31'h0, hit[i]});
    end
    apb(1'b1, ADR_SHADOW, 32'h13);
    op(OP_SWAP, 8'h00, 8'h00);
    chk("swap", {24'h0, flags}, 32'h13);
    apb(1'b0, ADR_SHADOW, 32'h0);
    chk("shadow rd", rd, 32'h41);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
  endtask

  // clock enable low freezes the flags, then work resumes
  task automatic t_hold();
    @(posedge clk);
    clk_en <= 1'b0;
    op(OP_CCF, 8'h00, 8'h00);
    chk("frozen flags", {24'h0, flags}, 32'h13);
    @(posedge clk);
    clk_en <= 1'b1;
    op(OP_CCF, 8'h00, 8'h00);
    chk("resume flags", {24'h0, flags}, 32'h10);
  endtask

  initial
  begin
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("reset flags", {24'h0, flags}, 32'h0);
    apb(1'b0, ADR_SHADOW, 32'h0);
    chk("reset shadow", rd, 32'h0);
    t_arith();
    t_shift();
    t_misc();
    t_regs();
    t_hold();
    final_report();
  end
endmodule
